// [rtl/cpu_clock_gen_osc_watchdog.sv]
// CPU clock source selector with strap capture and oscillator watchdog switchover.
// How it works
// - Every CPU clock edge gives a phase pulse.
// - Straps sampled around reset select clock mechanism.
// - Strap code maps to frequency factor F.
// - Code 001: toggle on each input rise.
// - Code 011: PLL bypassed, CPU follows input.
// - Other codes: PLL on, input times F.
// - Resync every input rise (two for code 000), period steps by one.
// - Watchdog guards direct and prescaler modes only.
// - Watchdog on after reset; config bit 4 disables.
// - Free clock counts; external edges clear count.
// - Failure after 16 free cycles without edge.
// - Failure: use free clock, raise interrupt flag.
// - Switchover sticks until hardware reset.
// - Disabled watchdog, codes 001/011: external clock, PLL powered down; PLL codes keep the PLL on.
`timescale 1ns/100ps
module cpu_clock_gen_osc_watchdog
  import clk_gen_pkg::*;
(
  input  wire logic                ref_clk,                // 100 MHz system clock.
  input  wire logic                reset,                  // Asynchronous reset, active high.
  input  wire logic                crystal_input_pin,      // Oscillator input, asynchronous.
  input  wire logic [2:0]          clock_mode_strap_pins,  // Mode straps, asynchronous.
  input  wire logic [SYSTEM_CONFIG_REGISTER_W-1:0] system_config_register, // Configuration word, bit 4 disables watchdog.
  input  wire logic                clock_fail_irq_clear,   // Clears the failure flag.
  output logic                     cpu_clk,                // Generated CPU clock level.
  output logic                     cpu_edge_pulse,         // One cycle per CPU clock edge.
  output logic                     clock_fail_irq,         // Sticky failure request.
  output logic                     on_free_run_clock,      // CPU runs on the free PLL clock.
  output logic                     pll_enable,             // PLL running.
  output logic                     pll_power_down,         // PLL switched off.
  output logic [1:0]               clock_mode              // Active mode code.
);
  clk_link_if lnk ();

  xtal_sync u_sync (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .crystal_input_pin (crystal_input_pin),
    .lnk               (lnk)
  );

  osc_watchdog u_wd (
    .ref_clk (ref_clk),
    .reset   (reset),
    .lnk     (lnk)
  );

  logic [2:0]        st1_reg, st2_reg, st1_next, st2_next;
  logic              pending_reg, pending_next;
  mode_t             mode_reg, mode_next;
  logic [PH_W-1:0]   target_reg, target_next;
  logic [1:0]        den_reg, den_next;
  logic              cpu_reg, cpu_next;
  logic              edge_reg, edge_next;
  logic              fail_reg, fail_next;
  logic              irq_reg, irq_next;
  logic              pll_en_reg, pll_en_next;
  logic              pwd_reg, pwd_next;
  logic [PLEN_W-1:0] plen_reg, plen_next;
  logic [PLEN_W-1:0] pcnt_reg, pcnt_next;
  logic [PH_W-1:0]   phases_reg, phases_next;
  logic [1:0]        rises_reg, rises_next;
  logic              wd_disable;
  logic              wd_on;
  logic              pll_toggle;

  assign wd_disable = system_config_register[WD_DISABLE_BIT];

  // Strap capture: pins are synchronised, then latched once on the first edge after release.
  always_comb begin
    st1_next     = clock_mode_strap_pins;
    st2_next     = st1_reg;
    pending_next = 1'b0;
    mode_next    = mode_reg;
    target_next  = target_reg;
    den_next     = den_reg;
    if (pending_reg) begin
      target_next = target_phases(st2_reg);
      den_next    = (st2_reg == STRAP_X2P5) ? DEN_TWO : DEN_ONE;
      unique case (st2_reg)
        STRAP_PRESCALE: mode_next = MODE_PRESCALE;
        STRAP_DIRECT:   mode_next = MODE_DIRECT;
        default:        mode_next = MODE_PLL;
      endcase
    end
  end

  // The strap synchroniser has no reset, so that it follows the pins while reset is held.
  always_ff @(posedge ref_clk) begin
    st1_reg <= st1_next;
    st2_reg <= st2_next;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pending_reg <= 1'b1;
      mode_reg    <= MODE_PLL;
      target_reg  <= PH_ZERO;
      den_reg     <= DEN_ONE;
    end else begin
      pending_reg <= pending_next;
      mode_reg    <= mode_next;
      target_reg  <= target_next;
      den_reg     <= den_next;
    end
  end

  // The watchdog only watches the external clock paths and only while enabled.
  assign wd_on         = !wd_disable && (mode_reg != MODE_PLL) && !pending_reg;
  assign lnk.wd_enable = wd_on;

  // Failure latch and request flag; a new failure wins over a clear in the same cycle.
  always_comb begin
    fail_next = fail_reg;
    irq_next  = clock_fail_irq_clear ? 1'b0 : irq_reg;
    if (lnk.wd_overflow && wd_on) begin
      fail_next = 1'b1;
      irq_next  = 1'b1;
    end
    pll_en_next = (mode_reg == MODE_PLL) || !wd_disable || fail_next;
    pwd_next    = !pll_en_next;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fail_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      pll_en_reg <= 1'b1;
      pwd_reg    <= 1'b0;
    end else begin
      fail_reg   <= fail_next;
      irq_reg    <= irq_next;
      pll_en_reg <= pll_en_next;
      pwd_reg    <= pwd_next;
    end
  end

  // CPU clock generation; PLL mode runs a phase timer trimmed by one step per window.
  always_comb begin
    cpu_next    = cpu_reg;
    plen_next   = plen_reg;
    pcnt_next   = pcnt_reg;
    phases_next = phases_reg;
    rises_next  = rises_reg;
    pll_toggle  = 1'b0;
    if (fail_reg) begin
      if (lnk.free_tick) begin
        cpu_next = ~cpu_reg;
      end
    end else if (mode_reg == MODE_DIRECT) begin
      cpu_next = lnk.xtal_level;
    end else if (mode_reg == MODE_PRESCALE) begin
      if (lnk.xtal_rise) begin
        cpu_next = ~cpu_reg;
      end
    end else if (!pending_reg) begin
      pcnt_next = pcnt_reg + 1'b1;
      if (pcnt_reg >= plen_reg - PLEN_ONE) begin
        pll_toggle  = 1'b1;
        cpu_next    = ~cpu_reg;
        pcnt_next   = '0;
        phases_next = phases_reg + PH_ONE;
      end
      if (lnk.xtal_rise) begin
        if (rises_reg >= den_reg - RISE_ONE) begin
          rises_next  = '0;
          phases_next = pll_toggle ? PH_ONE : PH_ZERO;
          if (phases_reg < target_reg && plen_reg > PLEN_MIN) begin
            plen_next = plen_reg - PLEN_ONE;
          end else if (phases_reg > target_reg) begin
            plen_next = plen_reg + PLEN_ONE;
          end
        end else begin
          rises_next = rises_reg + RISE_ONE;
        end
      end
    end
    edge_next = (cpu_next != cpu_reg);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cpu_reg    <= 1'b0;
      edge_reg   <= 1'b0;
      plen_reg   <= PLEN_RESET;
      pcnt_reg   <= '0;
      phases_reg <= '0;
      rises_reg  <= '0;
    end else begin
      cpu_reg    <= cpu_next;
      edge_reg   <= edge_next;
      plen_reg   <= plen_next;
      pcnt_reg   <= pcnt_next;
      phases_reg <= phases_next;
      rises_reg  <= rises_next;
    end
  end

  assign cpu_clk           = cpu_reg;
  assign cpu_edge_pulse    = edge_reg;
  assign clock_fail_irq    = irq_reg;
  assign on_free_run_clock = fail_reg;
  assign pll_enable        = pll_en_reg;
  assign pll_power_down    = pwd_reg;
  assign clock_mode        = mode_reg;

  property p_edge_pulse;
    @(posedge ref_clk) disable iff (reset) $changed(cpu_reg) |-> edge_reg;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("CPU clock edge without pulse");

  property p_fail_switch;
    @(posedge ref_clk) disable iff (reset) (lnk.wd_overflow && wd_on) |=> fail_reg && irq_reg;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("no switchover on overflow");

  property p_fail_sticky;
    @(posedge ref_clk) disable iff (reset) fail_reg |=> fail_reg;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("switchover undone without reset");

  property p_set_wins;
    @(posedge ref_clk) disable iff (reset) (lnk.wd_overflow && wd_on && clock_fail_irq_clear) |=> irq_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("failure flag lost to clear");

  property p_prescale;
    @(posedge ref_clk) disable iff (reset)
      (mode_reg == MODE_PRESCALE && !fail_reg && lnk.xtal_rise) |=> cpu_reg != $past(cpu_reg);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler missed input rise");

  property p_direct;
    @(posedge ref_clk) disable iff (reset)
      (mode_reg == MODE_DIRECT && !fail_reg) |=> cpu_reg == $past(lnk.xtal_level);
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive not following input");

  property p_power_down;
    @(posedge ref_clk) disable iff (reset)
      (wd_disable && mode_reg != MODE_PLL && !fail_reg) ##1 (wd_disable && !fail_reg) |-> pwd_reg && !pll_en_reg;
  endproperty
  a_power_down: assert property (p_power_down) else $error("PLL not powered down");

  property p_pll_step;
    @(posedge ref_clk) disable iff (reset)
      $changed(plen_reg) |-> (plen_reg == $past(plen_reg) + PLEN_ONE) || (plen_reg == $past(plen_reg) - PLEN_ONE);
  endproperty
  a_pll_step: assert property (p_pll_step) else $error("PLL period jumped");

  property p_pll_on;
    @(posedge ref_clk) disable iff (reset) (mode_reg == MODE_PLL) |=> pll_en_reg;
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("PLL off in PLL mode");

  property p_edge_real;
    @(posedge ref_clk) disable iff (reset) edge_reg |-> $changed(cpu_reg);
  endproperty
  a_edge_real: assert property (p_edge_real) else $error("edge pulse without CPU clock edge");

  property p_strap_hold;
    @(posedge ref_clk) disable iff (reset) !pending_reg |=> $stable(mode_reg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("clock mode changed after capture");

  property p_factor_den;
    @(posedge ref_clk) disable iff (reset) (pending_reg && st2_reg == STRAP_X2P5) |=> den_reg == DEN_TWO;
  endproperty
  a_factor_den: assert property (p_factor_den) else $error("half factor window not two rises");

  property p_prescale_mode;
    @(posedge ref_clk) disable iff (reset)
      (pending_reg && st2_reg == STRAP_PRESCALE) |=> mode_reg == MODE_PRESCALE;
  endproperty
  a_prescale_mode: assert property (p_prescale_mode) else $error("prescaler code not captured");

  property p_direct_mode;
    @(posedge ref_clk) disable iff (reset)
      (pending_reg && st2_reg == STRAP_DIRECT) |=> mode_reg == MODE_DIRECT;
  endproperty
  a_direct_mode: assert property (p_direct_mode) else $error("direct drive code not captured");

  property p_no_fail_pll;
    @(posedge ref_clk) disable iff (reset) (mode_reg == MODE_PLL) |-> !fail_reg;
  endproperty
  a_no_fail_pll: assert property (p_no_fail_pll) else $error("switchover in PLL mode");

  property p_disabled_no_fail;
    @(posedge ref_clk) disable iff (reset)
      (wd_disable && mode_reg != MODE_PLL && !fail_reg) |=> !fail_reg;
  endproperty
  a_disabled_no_fail: assert property (p_disabled_no_fail) else $error("switchover while disabled");

  property p_irq_clear;
    @(posedge ref_clk) disable iff (reset)
      (clock_fail_irq_clear && !(lnk.wd_overflow && wd_on)) |=> !irq_reg;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("failure flag not cleared");

  property p_free_toggle;
    @(posedge ref_clk) disable iff (reset) (fail_reg && lnk.free_tick) |=> cpu_reg != $past(cpu_reg);
  endproperty
  a_free_toggle: assert property (p_free_toggle) else $error("CPU clock not on free clock");
endmodule : cpu_clock_gen_osc_watchdog

// [rtl/clk_gen_pkg.sv]
// Constants, types and helpers for the CPU clock selector and oscillator watchdog.
package clk_gen_pkg;
  localparam int REF_CLK_HZ       = 100_000_000;
  localparam int FREE_RUN_HZ      = 5_000_000;
  localparam int FREE_HALF_CYCLES = REF_CLK_HZ / (2 * FREE_RUN_HZ);
  localparam int FREE_CNT_W       = 4;
  localparam logic [FREE_CNT_W-1:0] FREE_HALF_LAST = FREE_CNT_W'(FREE_HALF_CYCLES - 1);

  localparam int WD_CNT_W = 5;
  localparam logic [WD_CNT_W-1:0] WD_LAST = 5'h0f;

  localparam int SYSTEM_CONFIG_REGISTER_W        = 16;
  localparam int WD_DISABLE_BIT  = 4;

  localparam logic [2:0] STRAP_X4       = 3'h7;
  localparam logic [2:0] STRAP_X3       = 3'h6;
  localparam logic [2:0] STRAP_X2       = 3'h5;
  localparam logic [2:0] STRAP_X5       = 3'h4;
  localparam logic [2:0] STRAP_DIRECT   = 3'h3;
  localparam logic [2:0] STRAP_X10      = 3'h2;
  localparam logic [2:0] STRAP_PRESCALE = 3'h1;
  localparam logic [2:0] STRAP_X2P5     = 3'h0;

  localparam int PLEN_W = 12;
  localparam logic [PLEN_W-1:0] PLEN_RESET = 12'h00a;
  localparam logic [PLEN_W-1:0] PLEN_MIN   = 12'h001;
  localparam logic [PLEN_W-1:0] PLEN_ONE   = 12'h001;
  localparam int PH_W = 6;
  localparam logic [PH_W-1:0] PH_ONE  = 6'h01;
  localparam logic [PH_W-1:0] PH_ZERO = 6'h00;
  localparam logic [1:0] RISE_ONE = 2'h1;
  localparam logic [1:0] DEN_ONE  = 2'h1;
  localparam logic [1:0] DEN_TWO  = 2'h2;

  typedef enum logic [1:0] {
    MODE_PLL      = 2'b00,
    MODE_PRESCALE = 2'b01,
    MODE_DIRECT   = 2'b10
  } mode_t;

  // CPU clock phases expected per resynchronisation window (twice the numerator of F).
  function automatic logic [PH_W-1:0] target_phases(input logic [2:0] s);
    unique case (s)
      STRAP_X4:  target_phases = 6'h08;
      STRAP_X3:  target_phases = 6'h06;
      STRAP_X2:  target_phases = 6'h04;
      STRAP_X5:  target_phases = 6'h0a;
      STRAP_X10: target_phases = 6'h14;
      STRAP_X2P5: target_phases = 6'h0a;
      default:   target_phases = 6'h02;
    endcase
  endfunction : target_phases
endpackage : clk_gen_pkg

// [rtl/clk_link_if.sv]
// Signals shared between the clock selector and its synchroniser and watchdog.
`timescale 1ns/100ps
interface clk_link_if;
  logic xtal_level;
  logic xtal_rise;
  logic xtal_edge;
  logic free_tick;
  logic wd_enable;
  logic wd_overflow;
  modport sync_side (output xtal_level, output xtal_rise, output xtal_edge);
  modport wd_side   (input xtal_edge, input wd_enable, output free_tick, output wd_overflow);
  modport top_side  (input xtal_level, input xtal_rise, input xtal_edge, input free_tick,
                     input wd_overflow, output wd_enable);
endinterface : clk_link_if

// [rtl/xtal_sync.sv]
// Two-stage synchroniser and edge detector for the crystal input.
`timescale 1ns/100ps
module xtal_sync
  import clk_gen_pkg::*;
(
  input  wire logic   ref_clk,           // System clock.
  input  wire logic   reset,             // Asynchronous reset, active high.
  input  wire logic   crystal_input_pin, // Raw oscillator input.
  clk_link_if.sync_side lnk              // Synchronised level and edges.
);
  logic s1_reg, s2_reg, s3_reg;
  logic s1_next, s2_next, s3_next;

  always_comb begin
    s1_next = crystal_input_pin;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign lnk.xtal_level = s2_reg;
  assign lnk.xtal_rise  = s2_reg & ~s3_reg;
  assign lnk.xtal_edge  = s2_reg ^ s3_reg;
endmodule : xtal_sync

// [rtl/osc_watchdog.sv]
// Free-running PLL clock model and the oscillator watchdog counter.
`timescale 1ns/100ps
module osc_watchdog
  import clk_gen_pkg::*;
(
  input  wire logic   ref_clk, // System clock.
  input  wire logic   reset,   // Asynchronous reset, active high.
  clk_link_if.wd_side lnk      // Edge in, tick and overflow out.
);
  logic [FREE_CNT_W-1:0] div_reg, div_next;
  logic                  tick_reg, tick_next;
  logic                  phase_reg, phase_next;
  logic [WD_CNT_W-1:0]   cnt_reg, cnt_next;
  logic                  over_reg, over_next;
  logic                  full_cycle;

  always_comb begin
    tick_next  = (div_reg == FREE_HALF_LAST);
    div_next   = tick_next ? '0 : div_reg + 1'b1;
    phase_next = tick_next ? ~phase_reg : phase_reg;
    full_cycle = tick_next & phase_reg;
    over_next  = 1'b0;
    cnt_next   = cnt_reg;
    if (!lnk.wd_enable || lnk.xtal_edge) begin
      cnt_next = '0;
    end else if (full_cycle) begin
      if (cnt_reg == WD_LAST) begin
        cnt_next  = '0;
        over_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_reg   <= '0;
      tick_reg  <= 1'b0;
      phase_reg <= 1'b0;
      cnt_reg   <= '0;
      over_reg  <= 1'b0;
    end else begin
      div_reg   <= div_next;
      tick_reg  <= tick_next;
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      over_reg  <= over_next;
    end
  end

  assign lnk.free_tick   = tick_reg;
  assign lnk.wd_overflow = over_reg;

  property p_edge_clears;
    @(posedge ref_clk) disable iff (reset) lnk.xtal_edge |=> cnt_reg == '0;
  endproperty
  a_edge_clears: assert property (p_edge_clears) else $error("watchdog counter not cleared by edge");

  property p_overflow_at_16;
    @(posedge ref_clk) disable iff (reset) over_reg |-> $past(cnt_reg) == WD_LAST;
  endproperty
  a_overflow_at_16: assert property (p_overflow_at_16) else $error("overflow at wrong count");
endmodule : osc_watchdog

// [verification/xtal_osc_model.sv]
// Behavioural external oscillator that can be stopped to simulate a lost clock.
`timescale 1ns/100ps
module xtal_osc_model (
  input  wire logic        run,              // Oscillates while high, holds its level while low.
  input  wire logic [31:0] half_ns,          // Half period in ns.
  output logic             crystal_input_pin // Oscillator output.
);
  // A stopped crystal simply holds its last level; no edges reach the block.
  initial begin
    crystal_input_pin = 1'b0;
    forever begin
      if (run) #(half_ns) crystal_input_pin = ~crystal_input_pin;
      else #1;
    end
  end
endmodule : xtal_osc_model

// [verification/cpu_clock_gen_osc_watchdog_tb.sv]
// Self-checking bench for the CPU clock selector and oscillator watchdog.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module cpu_clock_gen_osc_watchdog_tb;
  import clk_gen_pkg::*;
  typedef struct {logic [5:0] fl; int lo; int hi;} note_t;
  logic                ref_clk, reset, crystal_input_pin, clock_fail_irq_clear;
  logic [2:0]          clock_mode_strap_pins;
  logic [SYSTEM_CONFIG_REGISTER_W-1:0] system_config_register;
  logic                cpu_clk, cpu_edge_pulse, clock_fail_irq, on_free_run_clock;
  logic                pll_enable, pll_power_down;
  logic [1:0]          clock_mode;
  logic                xrun, win_start, probe, prev_clk, edge_bad;
  int                  xhalf, n_fail, cmp_count;
  logic [15:0]         edge_cnt;
  note_t               note_q[$];
  note_t               nt;
  logic [5:0]          flags;
  assign flags = {clock_fail_irq, on_free_run_clock, pll_enable, pll_power_down, clock_mode};

  cpu_clock_gen_osc_watchdog dut_u (
    .ref_clk(ref_clk), .reset(reset), .crystal_input_pin(crystal_input_pin),
    .clock_mode_strap_pins(clock_mode_strap_pins), .system_config_register(system_config_register),
    .clock_fail_irq_clear(clock_fail_irq_clear), .cpu_clk(cpu_clk), .cpu_edge_pulse(cpu_edge_pulse),
    .clock_fail_irq(clock_fail_irq), .on_free_run_clock(on_free_run_clock), .pll_enable(pll_enable),
    .pll_power_down(pll_power_down), .clock_mode(clock_mode)
  );
  xtal_osc_model osc_u (.run(xrun), .half_ns(xhalf), .crystal_input_pin(crystal_input_pin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Output monitor: counts CPU clock edges in a window and checks each note at a probe.
  always @(posedge ref_clk) begin
    if (win_start) begin
      edge_cnt <= 16'h0000;
      edge_bad <= 1'b0;
    end else begin
      if (cpu_edge_pulse) edge_cnt <= edge_cnt + 16'h0001;
      if (cpu_edge_pulse !== (cpu_clk !== prev_clk)) edge_bad <= 1'b1;
    end
    prev_clk <= cpu_clk;
    if (probe) begin
      nt = note_q.pop_front();
      `CHK(flags, nt.fl)
      `CHK((edge_cnt >= nt.lo) && (edge_cnt <= nt.hi), 1'b1)
      `CHK(edge_bad, 1'b0)
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic do_reset(input logic [2:0] s, input logic [15:0] cfg);
    @(negedge ref_clk);
    reset = 1'b1;
    clock_mode_strap_pins = s;
    system_config_register = cfg;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : do_reset

  // Opens a window of about w cycles, then notes the expectation and probes at its end.
  task automatic measure(input int w, input int lo, input int hi, input logic [5:0] fl);
    @(negedge ref_clk) win_start = 1'b1;
    @(negedge ref_clk) win_start = 1'b0;
    repeat (w - 1) @(negedge ref_clk);
    note_q.push_back('{fl, lo, hi});
    probe = 1'b1;
    @(negedge ref_clk) probe = 1'b0;
  endtask : measure

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    static logic [2:0] codes[6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
    static int         phases[6] = '{8, 6, 4, 10, 20, 5};
    int         n;
    logic [1:0] m;
    reset = 1'b1;
    clock_mode_strap_pins = 3'h7;
    system_config_register = 16'h0000;
    clock_fail_irq_clear = 1'b0;
    xrun = 1'b0;
    xhalf = 50;
    win_start = 1'b0;
    probe = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'h2596));
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    // Direct drive and prescaler with the watchdog on: follow the input, then fail over for good.
    foreach (codes[i]) begin
      if (i > 1) break;
      m = (i == 0) ? 2'b10 : 2'b01;
      // Half periods in whole tens keep input edges away from the sampling edge.
      xhalf = 40 + 10 * ($urandom % 4);
      xrun = 1'b1;
      do_reset((i == 0) ? 3'h3 : 3'h1, 16'($urandom) & 16'hffef);
      n = (i == 0) ? 4000 / xhalf : 2000 / xhalf;
      measure(400, n - 2, n + 2, {4'b0010, m});
      xrun = 1'b0;
      // The second pass holds the clear across the failure, so the set must win for one cycle only.
      clock_fail_irq_clear = (i == 1);
      measure(290, 0, 2, {4'b0010, m});
      measure(80, 0, 10, {(i == 0), 3'b110, m});
      xrun = 1'b1;
      @(negedge ref_clk) clock_fail_irq_clear = 1'b1;
      @(negedge ref_clk) clock_fail_irq_clear = 1'b0;
      measure(200, 18, 22, {4'b0110, m});
      $display("test watchdog failover mode %b done", m);
    end
    // Prescaler with the watchdog disabled: PLL off, late strap changes ignored, no failover.
    xhalf = 40 + 10 * ($urandom % 4);
    do_reset(3'h1, 16'($urandom) | 16'h0010);
    clock_mode_strap_pins = 3'($urandom);
    n = 2000 / xhalf;
    measure(400, n - 2, n + 2, 6'b000101);
    xrun = 1'b0;
    measure(500, 0, 2, 6'b000101);
    $display("test watchdog disabled done");
    // PLL codes: settle, check the multiplied edge rate, then lose the input without failover.
    foreach (codes[i]) begin
      xhalf = 200;
      xrun = 1'b1;
      do_reset(codes[i], 16'($urandom));
      repeat (1200) @(negedge ref_clk);
      n = phases[i] * 20;
      measure(800, n - n / 10 - 4, n + n / 10 + 4, 6'b001000);
      xrun = 1'b0;
      // A PLL that loses its reference keeps its last period, so the edge rate holds.
      measure(500, n * 5 / 8 - n / 10 - 4, n * 5 / 8 + n / 10 + 4, 6'b001000);
      $display("test pll code %b done", codes[i]);
    end
    give_verdict();
  end
endmodule : cpu_clock_gen_osc_watchdog_tb
